//--- src/cbg_gen.sv
// colour-bar test pattern generator with bt656 framing
// Functional notes
// - seven equal bars: white yellow cyan green magenta red blue
// - ntsc luma 180 162 131 112 84 65 35
// - pal luma 235 then same as ntsc for other bars
// - blue chroma 128 44 156 72 184 100 212
// - red chroma 128 142 44 58 198 212 114
// - ntsc lines 720 pixels wide, bars spread over all 720 as in pal
// - ntsc field 1 244 lines: 240 image then 4 dark; field 2 243 lines: 240 image then 3 dark
// - pal field 288 lines, 720 pixels wide
// - progressive data framed by horizontal and vertical blanking
// - selected pattern replaces sensor stream at pipeline entry
// - bars encoded into bt656 stream with blanking periods
// - ntsc active lines 20-263 and 283-525
// - pal active lines 23-310 and 336-623
`timescale 1ns/1ps
`default_nettype none
module cbg_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic pattern_en,
    input wire logic pal_mode,
    // sensor side stream
    input wire logic [7:0] sensor_data,
    input wire logic sensor_valid,
    // image_flow_processor entry
    output logic [7:0] pipe_data,
    output logic pipe_valid,
    // bt656 stream
    output logic [7:0] bt_data,
    output logic bt_active,
    output logic bt_field
);
    logic [10:0] pix;
    logic [9:0] line;
    logic [10:0] next_pix;
    logic [9:0] next_line;
    logic [7:0] next_bt_data;
    logic next_bt_active;
    logic next_bt_field;
    logic [7:0] next_pipe_data;
    logic next_pipe_valid;
    logic field2;
    logic vblank;
    logic dark;
    logic [9:0] col;
    logic [2:0] bar;
    logic [7:0] lut_val;

    function automatic logic [7:0] trs(input logic f, input logic v, input logic h);
        logic p3, p2, p1, p0;
        p3 = v ^ h;
        p2 = f ^ h;
        p1 = f ^ v;
        p0 = f ^ v ^ h;
        trs = {1'b1, f, v, h, p3, p2, p1, p0};
    endfunction

    // active pixel column within the 720 wide picture
    assign col = 10'((pix - 11'd4) >> 1);
    assign bar = (col >= 10'(cbg_pkg::ACT_PIX)) ? 3'd6
        : 3'((32'(col) * cbg_pkg::BAR_CNT) / cbg_pkg::ACT_PIX);

    cbg_bar_lut u_lut (
        .bar(bar),
        .phase(pix[1:0]),
        .pal_mode(pal_mode),
        .value(lut_val)
    );

    always_comb
    begin
        field2 = 1'b0;
        vblank = 1'b1;
        dark = 1'b0;
        if (pal_mode)
        begin
            field2 = line >= 10'(cbg_pkg::PAL_F2_FIRST)
                && line <= 10'(cbg_pkg::PAL_LINES);
            vblank = !((line >= 10'(cbg_pkg::PAL_F1_ACT_FIRST)
                    && line <= 10'(cbg_pkg::PAL_F1_ACT_LAST))
                || (line >= 10'(cbg_pkg::PAL_F2_ACT_FIRST)
                    && line <= 10'(cbg_pkg::PAL_F2_ACT_LAST)));
        end
        else
        begin
            field2 = (line >= 10'(cbg_pkg::NTSC_F2_FIRST))
                || (line < 10'(cbg_pkg::NTSC_F1_FIRST));
            vblank = !((line >= 10'(cbg_pkg::NTSC_F1_ACT_FIRST)
                    && line <= 10'(cbg_pkg::NTSC_F1_ACT_LAST))
                || (line >= 10'(cbg_pkg::NTSC_F2_ACT_FIRST)
                    && line <= 10'(cbg_pkg::NTSC_F2_ACT_LAST)));
            // last lines of each field dark
            dark = (line > 10'(cbg_pkg::NTSC_F1_ACT_FIRST + cbg_pkg::NTSC_F1_IMG - 1)
                    && line <= 10'(cbg_pkg::NTSC_F1_ACT_LAST))
                || (line > 10'(cbg_pkg::NTSC_F2_ACT_FIRST + cbg_pkg::NTSC_F2_IMG - 1)
                    && line <= 10'(cbg_pkg::NTSC_F2_ACT_LAST));
        end
    end

    always_comb
    begin
        next_pix = pix + 11'd1;
        next_line = line;
        if (pix == 11'(cbg_pkg::LINE_CNT - 1))
        begin
            next_pix = cbg_pkg::PIX_RST;
            next_line = line + 10'd1;
            if (line == 10'(pal_mode ? cbg_pkg::PAL_LINES : cbg_pkg::NTSC_LINES))
                next_line = cbg_pkg::LINE_RST;
        end
        if (!pattern_en)
        begin
            next_pix = cbg_pkg::PIX_RST;
            next_line = cbg_pkg::LINE_RST;
        end
    end

    always_comb
    begin
        next_bt_field = field2;
        next_bt_active = 1'b0;
        next_bt_data = cbg_pkg::BLANK_C;
        // timing codes at line start and end
        if (pix < 11'd4 || (pix >= 11'(cbg_pkg::ACT_PIX * 2 + 4)
            && pix < 11'(cbg_pkg::ACT_PIX * 2 + 8)))
        begin
            case (pix[1:0])
                2'd0: next_bt_data = 8'hff;
                2'd3: next_bt_data = trs(field2, vblank, pix >= 11'd4);
                default: next_bt_data = 8'h00;
            endcase
        end
        else if (pix < 11'(cbg_pkg::ACT_PIX * 2 + 4) && !vblank && !dark)
        begin
            next_bt_active = 1'b1;
            next_bt_data = lut_val;
        end
        else if (pix[0])
            next_bt_data = cbg_pkg::BLANK_Y;
        else
            next_bt_data = cbg_pkg::BLANK_C;
        // idle chroma level, no stray sync bytes while off
        if (!pattern_en)
        begin
            next_bt_active = 1'b0;
            next_bt_data = cbg_pkg::BLANK_C;
        end
    end

    always_comb
    begin
        next_pipe_data = pattern_en ? next_bt_data : sensor_data;
        next_pipe_valid = pattern_en ? next_bt_active : sensor_valid;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pix <= cbg_pkg::PIX_RST;
            line <= cbg_pkg::LINE_RST;
            bt_data <= cbg_pkg::BLANK_C;
            bt_active <= 1'b0;
            bt_field <= 1'b0;
            pipe_data <= 8'h00;
            pipe_valid <= 1'b0;
        end
        else
        begin
            pix <= next_pix;
            line <= next_line;
            bt_data <= next_bt_data;
            bt_active <= next_bt_active;
            bt_field <= next_bt_field;
            pipe_data <= next_pipe_data;
            pipe_valid <= next_pipe_valid;
        end
    end

    property p_blank_level;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && vblank && pix == 11'h00b) |=> (bt_data == cbg_pkg::BLANK_Y);
    endproperty
    a_blank_level: assert property (p_blank_level) else $error("blank luma wrong");

    property p_sav;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && pix == 11'd0) |=> (bt_data == 8'hff) ##3 (bt_data[4] == 1'b0);
    endproperty
    a_sav: assert property (p_sav) else $error("sav code wrong");

    property p_first_bar;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && !vblank && !dark && pix == 11'd5 && !pal_mode)
            |=> (bt_data == 8'hb4);
    endproperty
    a_first_bar: assert property (p_first_bar) else $error("ntsc white wrong");

    property p_pal_white;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && !vblank && pix == 11'd5 && pal_mode) |=> (bt_data == 8'heb);
    endproperty
    a_pal_white: assert property (p_pal_white) else $error("pal white wrong");

    property p_blue_cb;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && !vblank && !dark && pix == 11'd1436) |=> (bt_data == 8'hd4);
    endproperty
    a_blue_cb: assert property (p_blue_cb) else $error("blue cb wrong");

    property p_yellow_cr;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && !vblank && !dark && pix == 11'd250) |=> (bt_data == 8'h8e);
    endproperty
    a_yellow_cr: assert property (p_yellow_cr) else $error("yellow cr wrong");

    property p_active_len;
        @(posedge core_clk) disable iff (rst)
        $rose(bt_active) && pattern_en |-> bt_active [*8];
    endproperty
    a_active_len: assert property (p_active_len) else $error("active run short");

    property p_ntsc_vbi;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && !pal_mode && line == 10'd10) |=> !bt_active;
    endproperty
    a_ntsc_vbi: assert property (p_ntsc_vbi) else $error("ntsc vbi active");

    property p_dark;
        @(posedge core_clk) disable iff (rst)
        (pattern_en && !pal_mode && line == 10'd261) |=> !bt_active;
    endproperty
    a_dark: assert property (p_dark) else $error("dark line active");

    property p_bypass;
        @(posedge core_clk) disable iff (rst)
        (!pattern_en && sensor_valid) |=> pipe_valid;
    endproperty
    a_bypass: assert property (p_bypass) else $error("sensor not passed");

    c_pal: cover property (@(posedge core_clk) disable iff (rst) pal_mode && bt_active);
    c_ntsc: cover property (@(posedge core_clk) disable iff (rst) !pal_mode && bt_active);
    c_field2: cover property (@(posedge core_clk) disable iff (rst) bt_field && bt_active);
endmodule // cbg_gen
`default_nettype wire

//--- src/cbg_pkg.sv
// package: constants for the colour-bar generator
package cbg_pkg;
    // line geometry
    localparam int ACT_PIX = 720;
    localparam int SRC_PIX = 640;
    localparam int BAR_CNT = 7;
    localparam int HBLANK_CNT = 268;
    localparam int LINE_CNT = ACT_PIX * 2 + HBLANK_CNT + 8;
    // ntsc frame
    localparam int NTSC_LINES = 525;
    localparam int NTSC_F1_ACT_FIRST = 20;
    localparam int NTSC_F1_ACT_LAST = 263;
    localparam int NTSC_F2_FIRST = 266;
    localparam int NTSC_F2_ACT_FIRST = 283;
    localparam int NTSC_F2_ACT_LAST = 525;
    localparam int NTSC_F1_IMG = 240;
    localparam int NTSC_F2_IMG = 240;
    localparam int NTSC_F1_FIRST = 4;
    // pal frame
    localparam int PAL_LINES = 625;
    localparam int PAL_F1_ACT_FIRST = 23;
    localparam int PAL_F1_ACT_LAST = 310;
    localparam int PAL_F2_FIRST = 313;
    localparam int PAL_F2_ACT_FIRST = 336;
    localparam int PAL_F2_ACT_LAST = 623;
    // levels
    localparam logic [7:0] BLANK_Y = 8'h10;
    localparam logic [7:0] BLANK_C = 8'h80;
    localparam logic [7:0] PAL_WHITE_Y = 8'heb;
    localparam logic [7:0] DARK_Y = 8'h10;
    // reset values
    localparam logic [10:0] PIX_RST = 11'h000;
    localparam logic [9:0] LINE_RST = 10'h001;
endpackage : cbg_pkg

//--- src/cbg_bar_lut.sv
// bar index and chroma phase to YCbCr byte lookup
`timescale 1ns/1ps
`default_nettype none
module cbg_bar_lut (
    // selection
    input wire logic [2:0] bar,
    input wire logic [1:0] phase,
    input wire logic pal_mode,
    // result
    output logic [7:0] value
);
    logic [7:0] y_tab [7];
    logic [7:0] cb_tab [7];
    logic [7:0] cr_tab [7];
    // ntsc luma
    assign y_tab = '{8'hb4, 8'ha2, 8'h83, 8'h70, 8'h54, 8'h41, 8'h23};
    // chroma blue difference
    assign cb_tab = '{8'h80, 8'h2c, 8'h9c, 8'h48, 8'hb8, 8'h64, 8'hd4};
    // chroma red difference
    assign cr_tab = '{8'h80, 8'h8e, 8'h2c, 8'h3a, 8'hc6, 8'hd4, 8'h72};

    always_comb
    begin
        value = cbg_pkg::BLANK_C;
        case (phase)
            2'd0: value = cb_tab[bar];
            2'd2: value = cr_tab[bar];
            default:
            begin
                if (pal_mode && bar == 3'd0)
                    value = cbg_pkg::PAL_WHITE_Y;
                else
                    value = y_tab[bar];
            end
        endcase
    end
endmodule // cbg_bar_lut
`default_nettype wire

//--- tb/cbg_sink.sv
// downstream bt656 sink: counts active bytes of each line
`timescale 1ns/1ps
`default_nettype none
module cbg_sink (
    // stream in
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] bt_data,
    input wire logic bt_active,
    // line summary
    output logic [11:0] line_act
);
    logic [23:0] hist;
    logic [11:0] run;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hist <= 24'h000000;
            run <= 12'h000;
            line_act <= 12'h000;
        end
        else
        begin
            hist <= {hist[15:0], bt_data};
            if (hist == 24'hff0000 && bt_data[4])
            begin
                line_act <= run;
                run <= 12'h000;
            end
            else if (bt_active)
                run <= run + 12'h001;
        end
    end
endmodule // cbg_sink
`default_nettype wire

//--- tb/ntsc_pal_color_bar_generator_test.sv
// testbench for the colour-bar generator
`timescale 1ns/1ps
`default_nettype none
module ntsc_pal_color_bar_generator_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic pattern_en = 1'b0;
    logic pal_mode = 1'b0;
    logic [7:0] sensor_data = 8'h00;
    logic sensor_valid = 1'b0;
    logic [7:0] pipe_data;
    logic pipe_valid;
    logic [7:0] bt_data;
    logic bt_active;
    logic bt_field;
    logic [11:0] line_act;
    int error_cnt = 0;
    int comparisons = 0;
    localparam logic [7:0] Y_TAB [7] = '{8'hb4, 8'ha2, 8'h83, 8'h70, 8'h54, 8'h41, 8'h23};
    localparam logic [7:0] CB_TAB [7] = '{8'h80, 8'h2c, 8'h9c, 8'h48, 8'hb8, 8'h64, 8'hd4};
    localparam logic [7:0] CR_TAB [7] = '{8'h80, 8'h8e, 8'h2c, 8'h3a, 8'hc6, 8'hd4, 8'h72};

    cbg_gen dut_u (.core_clk(core_clk), .rst(rst), .pattern_en(pattern_en),
        .pal_mode(pal_mode), .sensor_data(sensor_data), .sensor_valid(sensor_valid),
        .pipe_data(pipe_data), .pipe_valid(pipe_valid), .bt_data(bt_data),
        .bt_active(bt_active), .bt_field(bt_field));
    cbg_sink sink_u (.core_clk(core_clk), .rst(rst), .bt_data(bt_data),
        .bt_active(bt_active), .line_act(line_act));

    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [7:0] code_xy(input logic f, input logic v, input logic h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    function automatic logic [7:0] exp_byte(input int p, input logic pal, input logic f,
        input logic v);
        int b;
        b = ((p - 4) / 2) * 7 / 720;
        if (p == 0 || p == 1444)
            return 8'hff;
        if (p < 3 || (p > 1444 && p < 1447))
            return 8'h00;
        if (p == 3 || p == 1447)
            return code_xy(f, v, p == 1447);
        if (v || p > 1447)
            return p[0] ? 8'h10 : 8'h80;
        if (p[0])
            return (pal && b == 0) ? 8'heb : Y_TAB[b];
        return p[1] ? CR_TAB[b] : CB_TAB[b];
    endfunction

    task automatic t_pass();
        @(posedge core_clk);
        pattern_en <= 1'b0;
        sensor_data <= 8'h5a;
        sensor_valid <= 1'b1;
        @(negedge core_clk);
        @(negedge core_clk);
        check("pipe_data", {4'h0, pipe_data}, 12'h05a);
        check("pipe_valid", {11'h0, pipe_valid}, 12'h001);
        $display("test pass-through done");
    endtask

    // scan one line from its first byte
    task automatic line_scan(input logic pal, input logic f, input logic v);
        logic [7:0] e;
        logic a;
        for (int p = 0; p < 1450; p++)
        begin
            e = exp_byte(p, pal, f, v);
            a = !v && p >= 4 && p < 1444;
            check("bt_data", {4'h0, bt_data}, {4'h0, e});
            check("bt_active", {11'h0, bt_active}, {11'h0, a});
            check("pipe_data", {4'h0, pipe_data}, {4'h0, e});
            check("pipe_valid", {11'h0, pipe_valid}, {11'h0, a});
            if (p == 4)
                check("bt_field", {11'h0, bt_field}, {11'h0, f});
            @(negedge core_clk);
        end
        check("line_act", line_act, v ? 12'h000 : 12'h5a0);
    endtask

    task automatic t_frame(input logic pal);
        int n;
        @(posedge core_clk);
        pattern_en <= 1'b0;
        pal_mode <= pal;
        repeat (3) @(posedge core_clk);
        pattern_en <= 1'b1;
        n = 0;
        @(negedge core_clk);
        while (bt_data !== 8'hff)
        begin
            n++;
            if (n > 10)
            begin
                check("frame start", 12'h000, 12'h001);
                end_sim();
            end
            @(negedge core_clk);
        end
        line_scan(pal, !pal, 1'b1);
        repeat ((pal ? 21 : 18) * 1716 + 266) @(negedge core_clk);
        line_scan(pal, 1'b0, 1'b0);
        $display("test frame pal=%0d done", pal);
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_pass();
        t_frame(1'b0);
        t_frame(1'b1);
        t_pass();
        end_sim();
    end
endmodule // ntsc_pal_color_bar_generator_test
`default_nettype wire
